// ---- pkg/pci_cfg.svh ----
// Register offsets, reset values and field positions of the pin change block
`ifndef PCI_CFG_SVH
`define PCI_CFG_SVH
// Printed offsets are not all multiples of four: they are register indices
`define PCI_IDX_A_RISE    16'h1F3D
`define PCI_IDX_A_FALL    16'h1F3E
`define PCI_IDX_A_FLAGS   16'h1F3F
`define PCI_IDX_B_RISE    16'h1F48
`define PCI_IDX_B_FALL    16'h1F49
`define PCI_IDX_B_FLAGS   16'h1F4A
`define PCI_IDX_C_RISE    16'h1F53
`define PCI_IDX_C_FALL    16'h1F54
`define PCI_IDX_C_FLAGS   16'h1F55
// Control and status registers placed after the port registers
`define PCI_IDX_CTRL      16'h1F60
`define PCI_IDX_SUMMARY   16'h1F61
`define PCI_IDX_IRQ_STAT  16'h1F62
`define PCI_IDX_IRQ_MASK  16'h1F63
// Bit positions
`define PCI_CTRL_MASTER   0
`define PCI_STAT_SUMMARY  0
// Reset values
`define PCI_RST_BYTE      8'h00
`define PCI_RST_CTRL      1'b0
`endif

// ---- pkg/pci_pkg.sv ----
// Types shared by the pin change interrupt block
package pci_pkg;
	typedef logic [7:0] pci_byte_type;
	typedef logic [2:0][7:0] pci_ports_type;
	typedef struct packed {
		pci_ports_type rise_r;     // Rising edge enables
		pci_ports_type fall_r;     // Falling edge enables
		pci_ports_type flag_r;     // Sticky change flags
		pci_ports_type prev_r;     // Previous synchronised sample
		logic          master_r;   // Master change interrupt enable
		logic          istat_r;    // Sticky summary event status
		logic          imask_r;    // Interrupt mask
		logic          irq_r;      // Interrupt output
		logic          wake_r;     // Wake request output
		logic          summary_r;  // Registered summary output
		logic          pready_r;   // Bus ready
		logic          pslverr_r;  // Bus error
		logic [31:0]   prdata_r;   // Bus read data
	} pci_state_type;
endpackage

// ---- core/pci_sync.sv ----
// Three-stage synchroniser with agreement filter for the port pins
`timescale 1ns/100ps
module pci_sync
#(
	parameter int WIDTH = 24
)
(
	input  wire logic             pclk,     // System clock
	input  wire logic             presetn,  // Asynchronous reset, low
	input  wire logic [WIDTH-1:0] pin_in,   // Raw pin levels
	output logic      [WIDTH-1:0] pin_sync  // Filtered pin levels
);
	logic [WIDTH-1:0] s1_r;   // First stage, read only by s2
	logic [WIDTH-1:0] s2_r;   // Second stage
	logic [WIDTH-1:0] s3_r;   // Third stage
	logic [WIDTH-1:0] out_r;  // Accepted level

	// Shift the pins in; accept a level once stage two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			out_r <= '0;
		end
		else
		begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < WIDTH; i++)
			begin
				if (s2_r[i] == s3_r[i])
					out_r[i] <= s3_r[i];
			end
		end
	end

	assign pin_sync = out_r;
endmodule

// ---- core/pci_top.sv ----
// Pin change interrupt block for three ports with an APB register slave
//
// Overview of operation
// - Enabled edge on pin sets its flag
// - Request raised only with master enable set; the irq status output is not gated by it
// - Summary bit is OR of all flags
// - Summary read-only, clears when flags clear
// - Writing zero to a flag clears it
// - Edge during flag write leaves it set
// - Change event wakes device if enabled
// - Sleep edges recorded before first instruction
// - Rise enable one arms rising detection
// - Rise enable zero ignores rising edges
// - Fall enable one flags falling edges
// - Zero flag means none or cleared
// - Reset pin config disables its detection
// - Without master, flags still set
// - Both enables flag either polarity
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`include "pci_cfg.svh"
module pci_top
	import pci_pkg::*;
#(
	parameter int NPORT     = 3,   // Number of ports
	parameter int RST_PORT  = 0,   // Port holding the shared reset pin
	parameter int RST_BIT   = 3    // Bit of the shared reset pin
)
(
	input  wire logic        pclk,         // System clock, 10 MHz
	input  wire logic        presetn,      // Asynchronous reset, low
	input  wire logic        psel,         // APB select
	input  wire logic        penable,      // APB enable
	input  wire logic        pwrite,       // APB direction
	input  wire logic [31:0] paddr,        // APB byte address
	input  wire logic [31:0] pwdata,       // APB write data
	output logic      [31:0] prdata,       // APB read data
	output logic             pready,       // APB ready
	output logic             pslverr,      // APB error
	input  wire logic [7:0]  port_a_pins,  // Port A pin levels
	input  wire logic [7:0]  port_b_pins,  // Port B pin levels
	input  wire logic [7:0]  port_c_pins,  // Port C pin levels
	input  wire logic        reset_pin_enable,           // Reset pin config
	input  wire logic        low_voltage_program_enable, // LOW_VOLTAGE_PROGRAM_ENABLE config
	output logic             change_irq_summary,         // Summary of flags
	output logic             change_irq,   // Gated interrupt request
	output logic             wake_req,     // Wake from sleep
	output logic             irq           // Masked status interrupt
);
	pci_state_type st_r;   // Registered state
	pci_state_type st_nxt; // Next state

	logic [23:0]  pins_sync;  // Synchronised pins, port A in low byte
	logic [23:0]  rise_pulse; // One-cycle rising pulses
	logic [23:0]  fall_pulse; // One-cycle falling pulses
	logic [23:0]  edge_set;   // Enabled edges per pin
	logic [23:0]  pin_avail;  // Pins with detection available
	logic [23:0]  rise_flat;  // Rising enables flattened
	logic [23:0]  fall_flat;  // Falling enables flattened
	logic [23:0]  prev_flat;  // Previous sample flattened
	logic         rst_pin_lost; // Reset pin taken by configuration
	logic         cfg_s1_r;   // Config sync stage 1
	logic         cfg_s2_r;   // Config sync stage 2
	logic         cfg_s3_r;   // Config sync stage 3
	logic         cfg_r;      // Accepted config level
	logic         wr_acc;     // Write access phase
	logic         rd_acc;     // Read access phase
	logic [15:0]  idx;        // Register index from address
	logic         idx_ok;     // Address maps to a register
	logic [7:0]   wbyte;      // Write data low byte

	// Pin synchroniser
	pci_sync #(.WIDTH(24)) u_sync
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.pin_in   ({port_c_pins, port_b_pins, port_a_pins}),
		.pin_sync (pins_sync)
	);

	// Configuration straps also come from outside the clock domain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_s1_r <= 1'b0;
			cfg_s2_r <= 1'b0;
			cfg_s3_r <= 1'b0;
			cfg_r    <= 1'b0;
		end
		else
		begin
			cfg_s1_r <= reset_pin_enable | low_voltage_program_enable;
			cfg_s2_r <= cfg_s1_r;
			cfg_s3_r <= cfg_s2_r;
			if (cfg_s2_r == cfg_s3_r)
				cfg_r <= cfg_s3_r;
		end
	end

	assign rst_pin_lost = cfg_r;
	assign rise_flat = st_r.rise_r;
	assign fall_flat = st_r.fall_r;
	assign prev_flat = st_r.prev_r;

	// Per pin edge detection
	genvar g;
	generate
		for (g = 0; g < 24; g++)
		begin : g_pin
			// Shared reset pin loses detection when configured away
			assign pin_avail[g] = !(rst_pin_lost &&
				(g == RST_PORT * 8 + RST_BIT));
			// Compare new sample with previous one
			assign rise_pulse[g] = pins_sync[g] & ~prev_flat[g];
			assign fall_pulse[g] = ~pins_sync[g] & prev_flat[g];
			// Either enabled polarity sets the flag
			assign edge_set[g] = pin_avail[g] &
				((rise_pulse[g] & rise_flat[g]) |
				 (fall_pulse[g] & fall_flat[g]));
		end
	endgenerate

	// APB decode, printed offsets are indices, byte address is four times
	assign idx    = paddr[17:2];
	assign wr_acc = psel & penable & pwrite & ~st_r.pready_r;
	assign rd_acc = psel & penable & ~pwrite & ~st_r.pready_r;
	assign wbyte  = pwdata[7:0];
	assign idx_ok = (paddr[1:0] == 2'b00) && (paddr[31:18] == '0) &&
		(idx == `PCI_IDX_A_RISE  || idx == `PCI_IDX_A_FALL  ||
		 idx == `PCI_IDX_A_FLAGS || idx == `PCI_IDX_B_RISE  ||
		 idx == `PCI_IDX_B_FALL  || idx == `PCI_IDX_B_FLAGS ||
		 idx == `PCI_IDX_C_RISE  || idx == `PCI_IDX_C_FALL  ||
		 idx == `PCI_IDX_C_FLAGS || idx == `PCI_IDX_CTRL    ||
		 idx == `PCI_IDX_SUMMARY || idx == `PCI_IDX_IRQ_STAT ||
		 idx == `PCI_IDX_IRQ_MASK);

	// Next state: registers, flags, bus answer and outputs
	always_comb
	begin
		logic [2:0][7:0] fl;  // Working flag copy
		logic            any; // OR of all flags
		logic            ev;  // Any enabled edge this cycle
		fl  = st_r.flag_r;
		any = 1'b0;
		ev  = |edge_set;
		st_nxt = st_r;
		st_nxt.prev_r    = pins_sync;
		st_nxt.pready_r  = 1'b0;
		st_nxt.pslverr_r = 1'b0;
		// Register writes
		if (wr_acc && idx_ok)
		begin
			unique case (idx)
				`PCI_IDX_A_RISE:   st_nxt.rise_r[0] = wbyte;
				`PCI_IDX_A_FALL:   st_nxt.fall_r[0] = wbyte;
				`PCI_IDX_A_FLAGS:  fl[0] = fl[0] & wbyte;
				`PCI_IDX_B_RISE:   st_nxt.rise_r[1] = wbyte;
				`PCI_IDX_B_FALL:   st_nxt.fall_r[1] = wbyte;
				`PCI_IDX_B_FLAGS:  fl[1] = fl[1] & wbyte;
				`PCI_IDX_C_RISE:   st_nxt.rise_r[2] = wbyte;
				`PCI_IDX_C_FALL:   st_nxt.fall_r[2] = wbyte;
				`PCI_IDX_C_FLAGS:  fl[2] = fl[2] & wbyte;
				`PCI_IDX_CTRL:
					st_nxt.master_r = wbyte[`PCI_CTRL_MASTER];
				`PCI_IDX_IRQ_STAT:
					if (wbyte[`PCI_STAT_SUMMARY])
						st_nxt.istat_r = 1'b0;
				`PCI_IDX_IRQ_MASK:
					st_nxt.imask_r = wbyte[`PCI_STAT_SUMMARY];
				default:
					st_nxt.master_r = st_r.master_r; // Summary read-only
			endcase
		end
		// Hardware set wins over any write in the same cycle
		fl = fl | edge_set;
		st_nxt.flag_r = fl;
		any = |fl;
		// Sticky status event, set wins over clear
		if (ev)
			st_nxt.istat_r = 1'b1;
		// Read data
		if (rd_acc)
		begin
			st_nxt.prdata_r = 32'h0000_0000;
			unique case (idx)
				`PCI_IDX_A_RISE:   st_nxt.prdata_r[7:0] = st_r.rise_r[0];
				`PCI_IDX_A_FALL:   st_nxt.prdata_r[7:0] = st_r.fall_r[0];
				`PCI_IDX_A_FLAGS:  st_nxt.prdata_r[7:0] = st_r.flag_r[0];
				`PCI_IDX_B_RISE:   st_nxt.prdata_r[7:0] = st_r.rise_r[1];
				`PCI_IDX_B_FALL:   st_nxt.prdata_r[7:0] = st_r.fall_r[1];
				`PCI_IDX_B_FLAGS:  st_nxt.prdata_r[7:0] = st_r.flag_r[1];
				`PCI_IDX_C_RISE:   st_nxt.prdata_r[7:0] = st_r.rise_r[2];
				`PCI_IDX_C_FALL:   st_nxt.prdata_r[7:0] = st_r.fall_r[2];
				`PCI_IDX_C_FLAGS:  st_nxt.prdata_r[7:0] = st_r.flag_r[2];
				`PCI_IDX_CTRL:     st_nxt.prdata_r[0] = st_r.master_r;
				`PCI_IDX_SUMMARY:  st_nxt.prdata_r[0] = st_r.summary_r;
				`PCI_IDX_IRQ_STAT: st_nxt.prdata_r[0] = st_r.istat_r;
				`PCI_IDX_IRQ_MASK: st_nxt.prdata_r[0] = st_r.imask_r;
				default:           st_nxt.prdata_r = 32'h0000_0000;
			endcase
		end
		// One wait state, then ready; error on unmapped address
		if (psel && penable && !st_r.pready_r)
		begin
			st_nxt.pready_r  = 1'b1;
			st_nxt.pslverr_r = ~idx_ok;
		end
		// Outputs
		st_nxt.summary_r = any;
		st_nxt.irq_r     = any & st_nxt.master_r;
		st_nxt.wake_r    = any & st_nxt.master_r;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r.rise_r    <= {3{`PCI_RST_BYTE}};
			st_r.fall_r    <= {3{`PCI_RST_BYTE}};
			st_r.flag_r    <= {3{`PCI_RST_BYTE}};
			st_r.prev_r    <= '0;
			st_r.master_r  <= `PCI_RST_CTRL;
			st_r.istat_r   <= 1'b0;
			st_r.imask_r   <= 1'b0;
			st_r.irq_r     <= 1'b0;
			st_r.wake_r    <= 1'b0;
			st_r.summary_r <= 1'b0;
			st_r.pready_r  <= 1'b0;
			st_r.pslverr_r <= 1'b0;
			st_r.prdata_r  <= 32'h0000_0000;
		end
		else
			st_r <= st_nxt;
	end

	// Masked status interrupt output
	logic irq_r; // Registered status interrupt
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_r <= 1'b0;
		else
			irq_r <= st_nxt.istat_r & st_nxt.imask_r;
	end

	assign prdata             = st_r.prdata_r;
	assign pready             = st_r.pready_r;
	assign pslverr            = st_r.pslverr_r;
	assign change_irq_summary = st_r.summary_r;
	assign change_irq         = st_r.irq_r;
	assign wake_req           = st_r.wake_r;
	assign irq                = irq_r;

	// An enabled edge shows in the flags one cycle later
	chk_edge_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		edge_set[0] |=> st_r.flag_r[0][0])
		else $error("enabled edge did not set flag");
	// Zero write clears an unset-edge flag
	chk_zero_clears: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && idx_ok && idx == `PCI_IDX_A_FLAGS && !wbyte[0] &&
		!edge_set[0]
		|=> !st_r.flag_r[0][0])
		else $error("zero write did not clear flag");
	// Edge during clear keeps the flag set
	chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && idx == `PCI_IDX_A_FLAGS && edge_set[0]
		|=> st_r.flag_r[0][0])
		else $error("flag lost during clear");
	// Summary follows flag OR in the same cycle as the flags
	chk_summary_or: assert property (@(posedge pclk) disable iff (!presetn)
		##1 change_irq_summary == $past(|st_nxt.flag_r))
		else $error("summary not OR of flags");
	// Summary low only with all flags clear
	chk_summary_clr: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(change_irq_summary) |-> st_r.flag_r == '0)
		else $error("summary cleared with flags set");
	// No request while master disabled
	chk_master_gate: assert property (@(posedge pclk) disable iff (!presetn)
		change_irq |-> st_r.master_r)
		else $error("request without master enable");
	// Wake needs a set flag and master enable
	chk_wake_cause: assert property (@(posedge pclk) disable iff (!presetn)
		wake_req |-> change_irq_summary && st_r.master_r)
		else $error("wake without cause");
	// Disabled rising edge never sets flag
	chk_rise_off: assert property (@(posedge pclk) disable iff (!presetn)
		rise_pulse[0] && !rise_flat[0] |-> !edge_set[0])
		else $error("rising edge flagged while disabled");
	// Lost reset pin never flags
	chk_rst_pin: assert property (@(posedge pclk) disable iff (!presetn)
		rst_pin_lost |-> !edge_set[RST_PORT * 8 + RST_BIT])
		else $error("edge on reserved reset pin");
endmodule

// ---- verification/pci_pin_model.sv ----
// Far-side model driving the three port pin groups
`timescale 1ns/100ps
module pci_pin_model
(
	input  wire logic       pclk, // System clock
	output logic      [7:0] pa,   // Port A levels
	output logic      [7:0] pb,   // Port B levels
	output logic      [7:0] pc    // Port C levels
);
	// Pins idle low until a scenario moves them
	initial
	begin
		{pc, pb, pa} = 24'h000000;
	end

	// New levels after an edge, held long enough to pass the synchroniser
	task automatic drive(input logic [23:0] v);
		int n;
		@(posedge pclk);
		{pc, pb, pa} <= v;
		for (n = 0; n < 8; n++)
			@(posedge pclk);
	endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the pin change interrupt block
`timescale 1ns/100ps
`include "pci_cfg.svh"
module tb;
	typedef struct packed
	{
		logic        w;  // Write transfer
		logic [31:0] d;  // Expected read data
		logic        e;  // Expected error
	} pci_note_type;
	logic        pclk = 1'h0;      // System clock
	logic        presetn = 1'h0;   // Reset, active low
	logic        psel = 1'h0;      // APB select
	logic        penable = 1'h0;   // APB enable
	logic        pwrite = 1'h0;    // APB direction
	logic [31:0] paddr = '0;       // APB address
	logic [31:0] pwdata = '0;      // APB write data
	logic [31:0] prdata;           // APB read data
	logic        pready;           // APB ready
	logic        pslverr;          // APB error
	logic [31:0] rdata;            // Last word read
	logic [7:0]  pa, pb, pc;       // Pin levels
	logic        reset_pin_enable = 1'h0;           // Reset pin config
	logic        low_voltage_program_enable = 1'h0; // Programming config
	logic        summ, cirq, wake, irq; // Interrupt outputs
	pci_note_type notes[$];        // Expected bus results
	pci_note_type note;            // Note being checked
	int          failures = 0;     // Mismatches
	int          total_checks = 0; // Comparisons
	logic [15:0] ridx[3] = '{`PCI_IDX_A_RISE, `PCI_IDX_B_RISE,
		`PCI_IDX_C_RISE};
	logic [15:0] fidx[3] = '{`PCI_IDX_A_FALL, `PCI_IDX_B_FALL,
		`PCI_IDX_C_FALL};
	logic [15:0] gidx[3] = '{`PCI_IDX_A_FLAGS, `PCI_IDX_B_FLAGS,
		`PCI_IDX_C_FLAGS};

	pci_top dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_a_pins(pa),
		.port_b_pins(pb), .port_c_pins(pc),
		.reset_pin_enable(reset_pin_enable),
		.low_voltage_program_enable(low_voltage_program_enable),
		.change_irq_summary(summ), .change_irq(cirq), .wake_req(wake),
		.irq(irq)
	);
	pci_pin_model pins (.pclk(pclk), .pa(pa), .pb(pb), .pc(pc));

	// Free-running 10 MHz clock
	always #50 pclk = ~pclk;

	// Closing report and verdict
	task automatic conclude();
		$display("Checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Common comparison and error report
	task automatic cmp(input string n, input logic [31:0] e,
		input logic [31:0] s);
		total_checks++;
		if (s !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// Bus result compare
	task automatic check_bus(input string n, input logic [31:0] e,
		input logic [31:0] s);
		cmp(n, e, s);
	endtask

	// Output level compare, on values settled by the previous edge
	task automatic check_sig(input string n, input logic e);
		@(posedge pclk);
		case (n)
			"summary": cmp(n, {31'h0, e}, {31'h0, summ});
			"change_irq": cmp(n, {31'h0, e}, {31'h0, cirq});
			"wake_req": cmp(n, {31'h0, e}, {31'h0, wake});
			default: cmp(n, {31'h0, e}, {31'h0, irq});
		endcase
	endtask

	// One APB transfer; the note goes to the queue first
	task automatic apb(input logic w, input logic [15:0] idx,
		input logic [31:0] d, input logic [31:0] e, input logic err);
		int n;
		notes.push_back('{w, e, err});
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {14'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		rdata = prdata;
		if (n == 20)
		begin
			failures++;
			conclude();
		end
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [15:0] idx, input logic [31:0] e);
		apb(1'h0, idx, 32'h0, e, 1'h0);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		apb(1'h1, idx, d, 32'h0, 1'h0);
	endtask

	// Enabled edges between two pin patterns
	function automatic logic [23:0] edg(input logic [23:0] o, n, r, f);
		return (r & ~o & n) | (f & o & ~n);
	endfunction

	// Monitor: each completed transfer takes the oldest note
	always @(posedge pclk)
		if (psel && penable && pready === 1'h1)
		begin
			note = notes.pop_front();
			if (!note.w)
				check_bus("prdata", note.d, prdata);
			check_bus("pslverr", {31'h0, note.e}, {31'h0, pslverr});
		end

	// Main sequence
	initial
	begin
		logic [23:0] np, cur, re, fe, fl;
		logic        st;
		logic [1:0]  cfgs[4];
		int          p, k;
		cfgs = '{2'h1, 2'h2, 2'h3, 2'h0};
		cur = 24'h0;
		fl = 24'h0;
		st = 1'h0;
		void'($urandom(22181));
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		// Reset values, then a refused unmapped access
		for (p = 0; p < 3; p++)
		begin
			rd(ridx[p], 0);
			rd(fidx[p], 0);
			rd(gidx[p], 0);
		end
		rd(`PCI_IDX_CTRL, 0);
		rd(`PCI_IDX_IRQ_STAT, 0);
		apb(1'h0, 16'h1F40, 32'h0, 32'h0, 1'h1);
		// Random enables, port C armed for both polarities
		re = 24'($urandom);
		fe = 24'($urandom);
		re[23:16] = 8'hFF;
		fe[23:16] = 8'hFF;
		for (p = 0; p < 3; p++)
		begin
			wr(ridx[p], {24'h0, re[8*p+:8]});
			wr(fidx[p], {24'h0, fe[8*p+:8]});
			rd(ridx[p], {24'h0, re[8*p+:8]});
			rd(fidx[p], {24'h0, fe[8*p+:8]});
		end
		wr(`PCI_IDX_IRQ_MASK, 1);
		// Random pin patterns with the master enable off
		for (k = 0; k < 6; k++)
		begin
			np = 24'($urandom);
			fl |= edg(cur, np, re, fe);
			st |= |edg(cur, np, re, fe);
			pins.drive(np);
			cur = np;
			check_sig("summary", |fl);
			check_sig("change_irq", 1'h0);
			check_sig("irq", st);
			for (p = 0; p < 3; p++)
				rd(gidx[p], {24'h0, fl[8*p+:8]});
		end
		wr(`PCI_IDX_CTRL, 1);
		check_sig("change_irq", |fl);
		check_sig("wake_req", |fl);
		wr(`PCI_IDX_SUMMARY, 0);
		rd(`PCI_IDX_SUMMARY, {31'h0, |fl});
		// Status bit, mask and write-one clear
		wr(`PCI_IDX_IRQ_MASK, 0);
		check_sig("irq", 1'h0);
		wr(`PCI_IDX_IRQ_MASK, 1);
		check_sig("irq", st);
		wr(`PCI_IDX_IRQ_STAT, 1);
		rd(`PCI_IDX_IRQ_STAT, 0);
		// Clear each port with read, invert, write back
		for (p = 0; p < 3; p++)
		begin
			rd(gidx[p], {24'h0, fl[8*p+:8]});
			wr(gidx[p], {24'h0, ~rdata[7:0]});
			fl[8*p+:8] = 8'h00;
			rd(gidx[p], 0);
			check_sig("summary", |fl);
		end
		check_sig("change_irq", 1'h0);
		// Shared reset pin loses detection under either config
		wr(ridx[0], 32'h0000_00FF);
		wr(fidx[0], 32'h0000_00FF);
		for (k = 0; k < 4; k++)
		begin
			{low_voltage_program_enable, reset_pin_enable} <= cfgs[k];
			repeat (4) @(posedge pclk);
			np = cur ^ 24'h000008;
			pins.drive(np);
			cur = np;
			rd(gidx[0], (k == 3) ? 32'h8 : 32'h0);
		end
		conclude();
	end
endmodule
